// file: design/abe_pkg.sv
/*
  Constants, types and encodings shared by the execution core, its ALU and
  its synchroniser. Assumes a SystemVerilog-2012 compiler.
*/
package abe_pkg;

  // ==========================================================
  // Instruction word layout
  localparam int INSTR_W   = 24;
  localparam int OP_W      = 6;
  localparam int OP_LSB    = 18;
  localparam int REG_IDX_W = 5;
  localparam int RD_LSB    = 13;
  localparam int RR_LSB    = 8;
  localparam int BYTE_W    = 8;
  localparam int K_LSB     = 0;
  localparam int OFF_W     = 12;
  localparam int OFF_LSB   = 0;
  localparam int SEL_W     = 3;
  localparam int FSEL_LSB  = 12;
  localparam int BIT_LSB   = 0;
  localparam int WORD_W    = 16;
  localparam int NREGS     = 32;

  localparam logic [REG_IDX_W-1:0] Z_LO_IDX = 5'h1e;
  localparam logic [REG_IDX_W-1:0] Z_HI_IDX = 5'h1f;
  localparam logic [BYTE_W-1:0]    BYTE_ONES = 8'hff;
  localparam logic [BYTE_W-1:0]    BYTE_ONE  = 8'h01;

  // ==========================================================
  // Status flags, bit 7 down to bit 0
  typedef struct packed {
    logic i;
    logic t;
    logic h;
    logic s;
    logic v;
    logic n;
    logic z;
    logic c;
  } abe_flags_t;

  localparam abe_flags_t FLAGS_RST = '0;

  // ==========================================================
  // Operation codes, numbered from zero in this order
  typedef enum logic [OP_W-1:0] {
    OP_NOP, OP_ADD, OP_ADD_CARRY, OP_ADD_WORD, OP_SUB, OP_SUB_CONST,
    OP_SUB_WORD, OP_SUB_BORROW, OP_SUB_CONST_BORROW, OP_AND, OP_AND_CONST,
    OP_OR, OP_OR_CONST, OP_XOR, OP_SET_BITS, OP_CLR_BITS, OP_INC, OP_DEC,
    OP_TEST, OP_REL_JUMP, OP_IND_JUMP, OP_REL_CALL, OP_IND_CALL,
    OP_CMP_SKIP_EQ, OP_CMP, OP_CMP_CARRY, OP_CMP_CONST, OP_SKIP_REG_CLR,
    OP_SKIP_REG_SET, OP_SKIP_IO_CLR, OP_SKIP_IO_SET, OP_BR_FLAG_SET,
    OP_BR_FLAG_CLR, OP_BR_GE, OP_BR_LT, OP_BR_SAME_HIGHER, OP_BR_LOWER,
    OP_BR_IRQ_EN, OP_BR_IRQ_DIS, OP_WIDE
  } abe_op_t;

  // ==========================================================
  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_WAIT = 2'b11,
    ST_SKIP = 2'b10
  } abe_state_t;

  // ==========================================================
  // Cycle counts and derived wait counts
  localparam int CYC_WORD  = 2;
  localparam int CYC_JUMP  = 2;
  localparam int CYC_CALL  = 3;
  localparam int CYC_TAKEN = 2;
  localparam logic [1:0] WAIT_WORD  = 2'(CYC_WORD - 1);
  localparam logic [1:0] WAIT_JUMP  = 2'(CYC_JUMP - 1);
  localparam logic [1:0] WAIT_CALL  = 2'(CYC_CALL - 1);
  localparam logic [1:0] WAIT_TAKEN = 2'(CYC_TAKEN - 1);
  localparam logic [1:0] WAIT_LAST  = 2'h1;

  // ==========================================================
  // Register map, byte addresses
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] ADDR_CTRL  = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_PC    = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_STATE = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_RET   = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_WSEL  = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_WDATA = 8'h18;
  localparam int CTRL_RUN_BIT  = 0;
  localparam int STATE_CNT_LSB = 16;

endpackage

// file: design/abe_sync.sv
/*
  Two-stage synchroniser for a bus of asynchronous levels.
  Assumes an asynchronous active-low reset already released cleanly.
*/
`timescale 1ns/1ps
`default_nettype none
module abe_sync
  import abe_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_q;

  // ==========================================================
  // Two flops, first read only by second
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= '0;
      q_o    <= '0;
    end
    else
    begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule
`default_nettype wire

// file: design/abe_alu.sv
/*
  Eight-bit adder/subtractor with carry, half-carry and overflow.
  Assumes purely combinational use by the execution core.
*/
`timescale 1ns/1ps
`default_nettype none
module abe_alu
  import abe_pkg::*;
(
  input  wire logic [BYTE_W-1:0] a_i,
  input  wire logic [BYTE_W-1:0] b_i,
  input  wire logic              cin_i,
  input  wire logic              sub_i,
  output logic      [BYTE_W-1:0] res_o,
  output logic                   c_o,
  output logic                   h_o,
  output logic                   v_o
);

  localparam int NIB_W = BYTE_W / 2;

  logic [BYTE_W:0] sum;
  logic [NIB_W:0]  nib;
  logic            sa;
  logic            sb;

  // ==========================================================
  // Sum, borrow shows as carry out
  assign sum = sub_i ? {1'b0, a_i} - {1'b0, b_i} - (BYTE_W+1)'(cin_i)
                     : {1'b0, a_i} + {1'b0, b_i} + (BYTE_W+1)'(cin_i);
  assign nib = sub_i ? {1'b0, a_i[NIB_W-1:0]} - {1'b0, b_i[NIB_W-1:0]} - (NIB_W+1)'(cin_i)
                     : {1'b0, a_i[NIB_W-1:0]} + {1'b0, b_i[NIB_W-1:0]} + (NIB_W+1)'(cin_i);
  assign sa    = a_i[BYTE_W-1];
  assign sb    = b_i[BYTE_W-1];
  assign res_o = sum[BYTE_W-1:0];
  assign c_o   = sum[BYTE_W];
  assign h_o   = nib[NIB_W];

  // ==========================================================
  // Two's complement overflow
  assign v_o = (sub_i ? (sa != sb) : (sa == sb)) && (res_o[BYTE_W-1] != sa);

endmodule
`default_nettype wire

// file: design/abe_core.sv
/*
  Execution core for arithmetic, logic, branch, call, skip and compare
  instructions, with working registers, status flags and an Avalon-MM
  slave. Assumes program memory answers combinationally on pm_data_i
  in the same clock domain, and I/O pins are asynchronous.
*/
// Added by the designer: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module abe_core
  import abe_pkg::*;
#(
  parameter int PC_W = 16,
  parameter int IO_N = 4
) (
  input  wire logic                     sys_clk_i,
  input  wire logic                     rstn_i,
  output logic      [PC_W-1:0]          pm_addr_o,
  input  wire logic [INSTR_W-1:0]       pm_data_i,
  input  wire logic [IO_N*BYTE_W-1:0]   io_pins_i,
  output logic      [BYTE_W-1:0]        flags_o,
  input  wire logic [ADDR_W-1:0]        avs_address_i,
  input  wire logic                     avs_read_i,
  input  wire logic                     avs_write_i,
  input  wire logic [DATA_W-1:0]        avs_writedata_i,
  input  wire logic [DATA_W/BYTE_W-1:0] avs_byteenable_i,
  output logic      [DATA_W-1:0]        avs_readdata_o,
  output logic                          avs_waitrequest_o
);

  localparam int IO_IDX_W = $clog2(IO_N);
  localparam int IO_BIT_W = IO_IDX_W + SEL_W;
  localparam logic [PC_W-1:0] PC_ONE = PC_W'(1);
  localparam logic [PC_W-1:0] PC_TWO = PC_W'(2);

  // ==========================================================
  // Reset release
  logic [1:0] rst_q;
  logic       rst_n;

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rst_q <= 2'b00;
    else
      rst_q <= {rst_q[0], 1'b1};
  end

  assign rst_n = rst_q[1];

  // ==========================================================
  // State
  abe_state_t            st_q;
  abe_state_t            st_d;
  logic [PC_W-1:0]       pc_q;
  logic [PC_W-1:0]       pc_d;
  logic [PC_W-1:0]       ret_q;
  logic [PC_W-1:0]       ret_d;
  abe_flags_t            fl_q;
  abe_flags_t            fl_d;
  logic [1:0]            cnt_q;
  logic [1:0]            cnt_d;
  logic [BYTE_W-1:0]     wreg_q [NREGS];
  logic                  run_q;
  logic [REG_IDX_W-1:0]  wsel_q;
  logic [WORD_W-1:0]     icnt_q;
  logic                  wait_q;
  logic [DATA_W-1:0]     rdata_q;

  // ==========================================================
  // Instruction fields
  abe_op_t               op;
  logic [REG_IDX_W-1:0]  rd_idx;
  logic [REG_IDX_W-1:0]  rr_idx;
  logic [BYTE_W-1:0]     k8;
  logic [OFF_W-1:0]      off;
  logic [SEL_W-1:0]      fsel;
  logic [SEL_W-1:0]      bsel;
  logic [BYTE_W-1:0]     rd_v;
  logic [BYTE_W-1:0]     rr_v;
  logic [REG_IDX_W-1:0]  lo_idx;
  logic [REG_IDX_W-1:0]  hi_idx;

  assign op     = abe_op_t'(pm_data_i[OP_LSB +: OP_W]);
  assign rd_idx = pm_data_i[RD_LSB +: REG_IDX_W];
  assign rr_idx = pm_data_i[RR_LSB +: REG_IDX_W];
  assign k8     = pm_data_i[K_LSB +: BYTE_W];
  assign off    = pm_data_i[OFF_LSB +: OFF_W];
  assign fsel   = pm_data_i[FSEL_LSB +: SEL_W];
  assign bsel   = pm_data_i[BIT_LSB +: SEL_W];
  assign rd_v   = wreg_q[rd_idx];
  assign rr_v   = wreg_q[rr_idx];
  assign lo_idx = {rd_idx[REG_IDX_W-1:1], 1'b0};
  assign hi_idx = {rd_idx[REG_IDX_W-1:1], 1'b1};

  // ==========================================================
  // Operand classes
  logic is_imm;
  logic is_carry;
  logic is_sub;
  logic is_incdec;

  assign is_imm    = op inside {OP_SUB_CONST, OP_SUB_CONST_BORROW, OP_CMP_CONST,
                                OP_AND_CONST, OP_OR_CONST, OP_SET_BITS, OP_CLR_BITS};
  assign is_carry  = op inside {OP_ADD_CARRY, OP_SUB_BORROW, OP_SUB_CONST_BORROW,
                                OP_CMP_CARRY};
  assign is_sub    = op inside {OP_SUB, OP_SUB_CONST, OP_SUB_BORROW, OP_SUB_CONST_BORROW,
                                OP_CMP, OP_CMP_CARRY, OP_CMP_CONST, OP_DEC};
  assign is_incdec = op inside {OP_INC, OP_DEC};

  // ==========================================================
  // Byte arithmetic
  logic [BYTE_W-1:0] alu_b;
  logic [BYTE_W-1:0] alu_res;
  logic              alu_c;
  logic              alu_h;
  logic              alu_v;

  assign alu_b = is_imm ? k8 : (is_incdec ? BYTE_ONE : rr_v);

  abe_alu u_alu (
    .a_i   (rd_v),
    .b_i   (alu_b),
    .cin_i (is_carry & fl_q.c),
    .sub_i (is_sub),
    .res_o (alu_res),
    .c_o   (alu_c),
    .h_o   (alu_h),
    .v_o   (alu_v)
  );

  // ==========================================================
  // Logic results
  logic [BYTE_W-1:0] lop;
  logic [BYTE_W-1:0] lres;

  assign lop  = is_imm ? k8 : ((op == OP_TEST) ? rd_v : rr_v);
  assign lres = (op inside {OP_AND, OP_AND_CONST, OP_TEST}) ? (rd_v & lop) :
                (op == OP_XOR)      ? (rd_v ^ rr_v) :
                (op == OP_CLR_BITS) ? (rd_v & (BYTE_ONES - k8)) :
                (rd_v | lop);

  // ==========================================================
  // Word arithmetic on the register pair
  logic [WORD_W-1:0] wpair;
  logic [WORD_W:0]   wres;
  logic              w_sub;
  logic              w_v;
  logic              w_n;

  assign w_sub = (op == OP_SUB_WORD);
  assign wpair = {wreg_q[hi_idx], wreg_q[lo_idx]};
  assign wres  = w_sub ? {1'b0, wpair} - (WORD_W+1)'(k8)
                       : {1'b0, wpair} + (WORD_W+1)'(k8);
  assign w_n   = wres[WORD_W-1];
  assign w_v   = w_sub ? (wpair[WORD_W-1] & ~w_n) : (~wpair[WORD_W-1] & w_n);

  // ==========================================================
  // Flag images
  abe_flags_t fl_ar;
  abe_flags_t fl_lg;
  abe_flags_t fl_id;
  abe_flags_t fl_wd;

  assign fl_ar = '{i: fl_q.i, t: fl_q.t, h: alu_h, s: fl_q.s, v: alu_v,
                   n: alu_res[BYTE_W-1], z: (alu_res == '0), c: alu_c};
  assign fl_lg = '{i: fl_q.i, t: fl_q.t, h: fl_q.h, s: fl_q.s, v: 1'b0,
                   n: lres[BYTE_W-1], z: (lres == '0), c: fl_q.c};
  assign fl_id = '{i: fl_q.i, t: fl_q.t, h: fl_q.h, s: fl_q.s, v: alu_v,
                   n: alu_res[BYTE_W-1], z: (alu_res == '0), c: fl_q.c};
  assign fl_wd = '{i: fl_q.i, t: fl_q.t, h: fl_q.h, s: w_n ^ w_v, v: w_v,
                   n: w_n, z: (wres[WORD_W-1:0] == '0), c: wres[WORD_W]};

  // ==========================================================
  // Targets and conditions
  logic [IO_N*BYTE_W-1:0] io_s;
  logic [IO_BIT_W-1:0]    io_bit;
  logic [PC_W-1:0]        pc_rel;
  logic [PC_W-1:0]        zptr;
  logic                   br_take;
  logic                   sk_take;

  abe_sync #(
    .W (IO_N*BYTE_W)
  ) u_io_sync (
    .clk_i   (sys_clk_i),
    .rst_n_i (rst_n),
    .d_i     (io_pins_i),
    .q_o     (io_s)
  );

  assign io_bit = {rr_idx[IO_IDX_W-1:0], bsel};
  assign pc_rel = pc_q + PC_W'($signed(off)) + PC_ONE;
  assign zptr   = PC_W'({wreg_q[Z_HI_IDX], wreg_q[Z_LO_IDX]});

  assign br_take = (op == OP_BR_FLAG_SET)    ?  fl_q[fsel] :
                   (op == OP_BR_FLAG_CLR)    ? ~fl_q[fsel] :
                   (op == OP_BR_GE)          ? ~(fl_q.n ^ fl_q.v) :
                   (op == OP_BR_LT)          ?  (fl_q.n ^ fl_q.v) :
                   (op == OP_BR_SAME_HIGHER) ? ~fl_q.c :
                   (op == OP_BR_LOWER)       ?  fl_q.c :
                   (op == OP_BR_IRQ_EN)      ?  fl_q.i :
                   (op == OP_BR_IRQ_DIS)     ? ~fl_q.i : 1'b0;

  assign sk_take = (op == OP_CMP_SKIP_EQ)  ? (rd_v == rr_v) :
                   (op == OP_SKIP_REG_CLR) ? ~rr_v[bsel] :
                   (op == OP_SKIP_REG_SET) ?  rr_v[bsel] :
                   (op == OP_SKIP_IO_CLR)  ? ~io_s[io_bit] :
                   (op == OP_SKIP_IO_SET)  ?  io_s[io_bit] : 1'b0;

  // ==========================================================
  // Sequencer and execute
  logic                  we;
  logic                  we_hi;
  logic [BYTE_W-1:0]     wval;
  logic [REG_IDX_W-1:0]  widx;

  always_comb
  begin
    st_d  = st_q;
    pc_d  = pc_q;
    ret_d = ret_q;
    fl_d  = fl_q;
    cnt_d = cnt_q;
    we    = 1'b0;
    we_hi = 1'b0;
    wval  = alu_res;
    widx  = rd_idx;
    unique case (st_q)
      ST_IDLE:
      begin
        if (run_q)
          st_d = ST_EXEC;
      end
      ST_EXEC:
      begin
        if (!run_q)
          st_d = ST_IDLE;
        else
        begin
          pc_d = pc_q + PC_ONE;
          unique case (op)
            OP_ADD, OP_ADD_CARRY,
            OP_SUB, OP_SUB_CONST,
            OP_SUB_BORROW, OP_SUB_CONST_BORROW:
            begin
              we   = 1'b1;
              fl_d = fl_ar;
            end
            OP_ADD_WORD, OP_SUB_WORD:
            begin
              we    = 1'b1;
              we_hi = 1'b1;
              widx  = lo_idx;
              wval  = wres[BYTE_W-1:0];
              fl_d  = fl_wd;
              st_d  = ST_WAIT;
              cnt_d = WAIT_WORD;
            end
            OP_AND, OP_AND_CONST, OP_OR, OP_OR_CONST, OP_XOR,
            OP_SET_BITS, OP_CLR_BITS, OP_TEST:
            begin
              we   = 1'b1;
              wval = lres;
              fl_d = fl_lg;
            end
            OP_INC, OP_DEC:
            begin
              we   = 1'b1;
              fl_d = fl_id;
            end
            OP_REL_JUMP, OP_IND_JUMP:
            begin
              pc_d  = (op == OP_IND_JUMP) ? zptr : pc_rel;
              st_d  = ST_WAIT;
              cnt_d = WAIT_JUMP;
            end
            OP_REL_CALL, OP_IND_CALL:
            begin
              ret_d = pc_q + PC_ONE;
              pc_d  = (op == OP_IND_CALL) ? zptr : pc_rel;
              st_d  = ST_WAIT;
              cnt_d = WAIT_CALL;
            end
            OP_CMP, OP_CMP_CARRY, OP_CMP_CONST:
              fl_d = fl_ar;
            OP_CMP_SKIP_EQ, OP_SKIP_REG_CLR, OP_SKIP_REG_SET,
            OP_SKIP_IO_CLR, OP_SKIP_IO_SET:
            begin
              if (sk_take)
                st_d = ST_SKIP;
            end
            OP_BR_FLAG_SET, OP_BR_FLAG_CLR, OP_BR_GE, OP_BR_LT,
            OP_BR_SAME_HIGHER, OP_BR_LOWER, OP_BR_IRQ_EN, OP_BR_IRQ_DIS:
            begin
              if (br_take)
              begin
                pc_d  = pc_rel;
                st_d  = ST_WAIT;
                cnt_d = WAIT_TAKEN;
              end
            end
            OP_WIDE:
              pc_d = pc_q + PC_TWO;
            default:
              pc_d = pc_q + PC_ONE;
          endcase
        end
      end
      ST_WAIT:
      begin
        cnt_d = cnt_q - WAIT_LAST;
        if (cnt_q == WAIT_LAST)
          st_d = ST_EXEC;
      end
      ST_SKIP:
      begin
        pc_d = (op == OP_WIDE) ? pc_q + PC_TWO : pc_q + PC_ONE;
        st_d = ST_EXEC;
      end
    endcase
  end

  // ==========================================================
  // Bus decode
  logic              req;
  logic              bus_wr;
  logic [DATA_W-1:0] wmask;
  logic [DATA_W-1:0] rd_mux;
  logic              be0;
  logic              sel_ctrl;
  logic              sel_flags;
  logic              sel_pc;
  logic              sel_state;
  logic              sel_ret;
  logic              sel_wsel;
  logic              sel_wdata;

  assign req       = avs_read_i | avs_write_i;
  assign bus_wr    = avs_write_i & ~wait_q;
  assign be0       = avs_byteenable_i[0];
  assign sel_ctrl  = (avs_address_i == ADDR_CTRL);
  assign sel_flags = (avs_address_i == ADDR_FLAGS);
  assign sel_pc    = (avs_address_i == ADDR_PC);
  assign sel_state = (avs_address_i == ADDR_STATE);
  assign sel_ret   = (avs_address_i == ADDR_RET);
  assign sel_wsel  = (avs_address_i == ADDR_WSEL);
  assign sel_wdata = (avs_address_i == ADDR_WDATA);

  always_comb
  begin
    wmask = '0;
    for (int b = 0; b < DATA_W/BYTE_W; b++)
      wmask[b*BYTE_W +: BYTE_W] = {BYTE_W{avs_byteenable_i[b]}};
  end

  assign rd_mux = sel_ctrl  ? DATA_W'(run_q) :
                  sel_flags ? DATA_W'(fl_q) :
                  sel_pc    ? DATA_W'(pc_q) :
                  sel_state ? (DATA_W'(st_q) | (DATA_W'(icnt_q) << STATE_CNT_LSB)) :
                  sel_ret   ? DATA_W'(ret_q) :
                  sel_wsel  ? DATA_W'(wsel_q) :
                  sel_wdata ? DATA_W'(wreg_q[wsel_q]) : '0;

  // ==========================================================
  // Bus slave registers
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wait_q  <= 1'b1;
      rdata_q <= '0;
      run_q   <= 1'b0;
      wsel_q  <= '0;
    end
    else
    begin
      wait_q <= ~(req & wait_q);
      if (req & wait_q)
        rdata_q <= rd_mux;
      if (bus_wr & sel_ctrl & be0)
        run_q <= avs_writedata_i[CTRL_RUN_BIT];
      if (bus_wr & sel_wsel & be0)
        wsel_q <= avs_writedata_i[REG_IDX_W-1:0];
    end
  end

  // ==========================================================
  // Core state registers; bus writes to PC and flags win
  logic [PC_W-1:0] pc_mask;

  assign pc_mask = PC_W'(wmask);

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q   <= ST_IDLE;
      pc_q   <= '0;
      ret_q  <= '0;
      fl_q   <= FLAGS_RST;
      cnt_q  <= '0;
      icnt_q <= '0;
    end
    else
    begin
      st_q  <= st_d;
      ret_q <= ret_d;
      cnt_q <= cnt_d;
      if (bus_wr & sel_pc)
        pc_q <= (pc_q & ~pc_mask) | (PC_W'(avs_writedata_i) & pc_mask);
      else
        pc_q <= pc_d;
      if (bus_wr & sel_flags & be0)
        fl_q <= abe_flags_t'(avs_writedata_i[BYTE_W-1:0]);
      else
        fl_q <= fl_d;
      if ((st_q == ST_EXEC) & run_q)
        icnt_q <= icnt_q + WORD_W'(1);
    end
  end

  // ==========================================================
  // Working registers; core write wins over bus
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      wreg_q <= '{default: '0};
    else
    begin
      if (bus_wr & sel_wdata & be0)
        wreg_q[wsel_q] <= avs_writedata_i[BYTE_W-1:0];
      if (we)
        wreg_q[widx] <= wval;
      if (we_hi)
        wreg_q[hi_idx] <= wres[WORD_W-1:BYTE_W];
    end
  end

  // ==========================================================
  // Outputs
  assign pm_addr_o         = pc_q;
  assign flags_o           = fl_q;
  assign avs_readdata_o    = rdata_q;
  assign avs_waitrequest_o = wait_q;

endmodule
`default_nettype wire

// file: sim/abe_pmem.sv
/* Program memory model: one instruction word per address, answered at once.
   Assumes the bench loads rom before the core runs; unloaded words are NOP. */
`timescale 1ns/1ps
`default_nettype none
module abe_pmem
  import abe_pkg::*;
#(
  parameter int PC_W = 16
) (
  input  wire logic [PC_W-1:0]    addr_i,
  output logic      [INSTR_W-1:0] data_o
);
  logic [INSTR_W-1:0] rom [64];
  initial foreach (rom[i]) rom[i] = '0;
  assign data_o = (addr_i < 16'd64) ? rom[addr_i[5:0]] : '0;
endmodule
`default_nettype wire

// file: sim/abe_core_monitor.sv
/* Port checker for the execution core.
   Assumes no bus write while checked instructions run. */
`timescale 1ns/1ps
`default_nettype none
module abe_core_monitor
  import abe_pkg::*;
#(
  parameter int PC_W = 16
) (
  input wire logic               sys_clk_i,
  input wire logic               rstn_i,
  input wire logic [PC_W-1:0]    pm_addr_o,
  input wire logic [INSTR_W-1:0] pm_data_i,
  input wire logic [BYTE_W-1:0]  flags_o,
  input wire logic               avs_read_i,
  input wire logic               avs_write_i,
  input wire logic               avs_waitrequest_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  // ==========================================
  // Decode
  wire [OP_W-1:0] op = pm_data_i[OP_LSB+:OP_W];
  wire [2:0] sel = pm_data_i[FSEL_LSB+:SEL_W];
  wire [PC_W-1:0] tgt = pm_addr_o + PC_W'($signed(pm_data_i[OFF_W-1:0])) + 1'b1;
  wire br = op inside {[OP_BR_FLAG_SET:OP_BR_IRQ_DIS]} && !avs_write_i;
  wire tk = (op == OP_BR_FLAG_SET) ? flags_o[sel] : (op == OP_BR_FLAG_CLR) ? !flags_o[sel] :
            (op == OP_BR_GE) ? !(flags_o[3] ^ flags_o[2]) : (op == OP_BR_LT) ? (flags_o[3] ^ flags_o[2]) :
            (op == OP_BR_SAME_HIGHER) ? !flags_o[0] : (op == OP_BR_LOWER) ? flags_o[0] :
            (op == OP_BR_IRQ_EN) ? flags_o[7] : !flags_o[7];
  wire lg = op inside {[OP_AND:OP_CLR_BITS], OP_TEST} && !avs_write_i;
  // ==========================================
  // Properties
  property p_bus_wait;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_bus_wait: assert property (p_bus_wait) else $error("no answer one cycle after request");
  property p_bus_one;
    !avs_waitrequest_o |=> avs_waitrequest_o;
  endproperty
  a_bus_one: assert property (p_bus_one) else $error("waitrequest low too long");
  property p_br_taken;
    br && tk |=> $stable(pm_addr_o) or (pm_addr_o == $past(tgt) ##1 $stable(pm_addr_o));
  endproperty
  a_br_taken: assert property (p_br_taken) else $error("taken branch wrong");
  property p_br_untaken;
    br && !tk |=> $stable(pm_addr_o) || pm_addr_o == $past(pm_addr_o) + 1'b1;
  endproperty
  a_br_untaken: assert property (p_br_untaken) else $error("untaken branch wrong");
  property p_jump;
    op == OP_REL_JUMP && !avs_write_i |=> $stable(pm_addr_o) or (pm_addr_o == $past(tgt) ##1 $stable(pm_addr_o));
  endproperty
  a_jump: assert property (p_jump) else $error("relative jump wrong");
  property p_call;
    op == OP_REL_CALL && !avs_write_i |=> $stable(pm_addr_o) or (pm_addr_o == $past(tgt) ##1 $stable(pm_addr_o)[*2]);
  endproperty
  a_call: assert property (p_call) else $error("relative call wrong");
  property p_keep_flags;
    op inside {[OP_REL_JUMP:OP_CMP_SKIP_EQ], [OP_SKIP_REG_CLR:OP_BR_IRQ_DIS]} && !avs_write_i |=> $stable(flags_o);
  endproperty
  a_keep_flags: assert property (p_keep_flags) else $error("flags changed by flow op");
  property p_logic_v;
    lg ##1 pm_addr_o != $past(pm_addr_o) |-> !flags_o[3];
  endproperty
  a_logic_v: assert property (p_logic_v) else $error("logic op left overflow set");
endmodule
bind abe_core abe_core_monitor #(.PC_W(PC_W)) u_mon (.sys_clk_i, .rstn_i, .pm_addr_o, .pm_data_i, .flags_o,
  .avs_read_i, .avs_write_i, .avs_waitrequest_o);
`default_nettype wire

// file: sim/abe_core_tb.sv
/* Self-checking bench: registers over Avalon-MM, then a short program.
   Assumes the program memory model abe_pmem. */
`timescale 1ns/1ps
`default_nettype none
module abe_core_tb
  import abe_pkg::*;
;
  logic               sys_clk_i = 1'b0;
  logic               rstn_i = 1'b0;
  logic               avs_read_i = 1'b0;
  logic               avs_write_i = 1'b0;
  logic [ADDR_W-1:0]  avs_address_i = '0;
  logic [DATA_W-1:0]  avs_writedata_i = '0;
  logic [3:0]         avs_byteenable_i = 4'hf;
  logic [31:0]        io_pins_i = 32'h0000_0100;
  logic [15:0]        pm_addr_o;
  logic [INSTR_W-1:0] pm_data_i;
  logic [7:0]         flags_o;
  logic [DATA_W-1:0]  avs_readdata_o;
  logic [DATA_W-1:0]  q;
  logic               avs_waitrequest_o;
  int                 n_mismatch = 0;
  int                 n_compared = 0;
  int                 cyc = 0;
  initial forever #25 sys_clk_i = ~sys_clk_i;
  abe_core #(.PC_W(16), .IO_N(4)) DUT (.sys_clk_i, .rstn_i, .pm_addr_o, .pm_data_i, .io_pins_i, .flags_o,
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
    .avs_waitrequest_o);
  abe_pmem #(.PC_W(16)) u_pm (.addr_i(pm_addr_o), .data_o(pm_data_i));
  // ==========================================
  // Tasks
  task automatic summarize();
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, '0);
    n_compared++;
    if (q !== e)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, q, e);
    end
  endtask
  function automatic logic [23:0] ins(abe_op_t o, int f);
    return {o, 18'(f)};
  endfunction
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      summarize();
    end
  end
  // ==========================================
  // Main sequence
  initial
  begin
    repeat (8) @(posedge sys_clk_i);
    u_pm.rom[0] = ins(OP_ADD, 1 << 13 | 2 << 8);
    u_pm.rom[1] = ins(OP_BR_FLAG_SET, 5 << 12 | 2);
    u_pm.rom[2] = ins(OP_ADD, 2 << 13 | 2 << 8);
    u_pm.rom[4] = ins(OP_SUB_CONST, 1 << 13 | 8'h11);
    u_pm.rom[5] = ins(OP_BR_LOWER, 1);
    u_pm.rom[6] = ins(OP_ADD, 2 << 13 | 2 << 8);
    u_pm.rom[7] = ins(OP_BR_GE, 8);
    u_pm.rom[8] = ins(OP_SKIP_REG_SET, 1 << 8 | 7);
    u_pm.rom[9] = ins(OP_WIDE, 0);
    u_pm.rom[10] = ins(OP_REL_JUMP, 4);
    u_pm.rom[11] = ins(OP_AND_CONST, 1 << 13 | 8'h80);
    u_pm.rom[12] = ins(OP_SKIP_IO_CLR, 1 << 8);
    u_pm.rom[13] = ins(OP_REL_CALL, 1);
    u_pm.rom[15] = ins(OP_REL_JUMP, 12'hfff);
    u_pm.rom[16] = ins(OP_SUB_WORD, 4 << 13 | 1);
    u_pm.rom[17] = ins(OP_SUB_CONST_BORROW, 5 << 13);
    u_pm.rom[18] = ins(OP_CMP_SKIP_EQ, 4 << 13 | 4 << 8);
    u_pm.rom[19] = ins(OP_INC, 4 << 13);
    u_pm.rom[20] = ins(OP_SET_BITS, 2 << 13 | 8'h40);
    u_pm.rom[21] = ins(OP_CLR_BITS, 5 << 13 | 8'h0e);
    u_pm.rom[22] = ins(OP_DEC, 2 << 13);
    u_pm.rom[23] = ins(OP_TEST, 1 << 13);
    u_pm.rom[24] = ins(OP_BR_IRQ_DIS, 5);
    u_pm.rom[25] = ins(OP_BR_IRQ_EN, 1);
    u_pm.rom[27] = ins(OP_CMP_CONST, 2 << 13 | 8'h40);
    u_pm.rom[28] = ins(OP_BR_FLAG_CLR, 1 << 12 | 3);
    u_pm.rom[29] = ins(OP_IND_JUMP, 0);
    u_pm.rom[30] = ins(OP_INC, 2 << 13);
    u_pm.rom[31] = ins(OP_REL_JUMP, 12'hfff);
    rstn_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    rc(ADDR_FLAGS, 32'h0);
    rc(ADDR_PC, 32'h0);
    rc(8'h40, 32'h0);
    bus(1'b1, ADDR_FLAGS, 32'h80);
    rc(ADDR_FLAGS, 32'h80);
    bus(1'b1, ADDR_WSEL, 32'h2);
    bus(1'b1, ADDR_WDATA, 32'h1);
    bus(1'b1, ADDR_WSEL, 32'h1);
    bus(1'b1, ADDR_WDATA, 32'h0f);
    rc(ADDR_WDATA, 32'h0f);
    $display("registers test done");
    bus(1'b1, ADDR_CTRL, 32'h1);
    do bus(1'b0, ADDR_PC, '0); while (q !== 32'hf);
    rc(ADDR_RET, 32'he);
    rc(ADDR_FLAGS, 32'ha5);
    rc(ADDR_WDATA, 32'h80);
    bus(1'b1, ADDR_WSEL, 32'h2);
    rc(ADDR_WDATA, 32'h1);
    $display("program test done");
    bus(1'b1, ADDR_WSEL, 32'h1e);
    bus(1'b1, ADDR_WDATA, 32'h1f);
    bus(1'b1, ADDR_PC, 32'h10);
    do bus(1'b0, ADDR_PC, '0); while (q !== 32'h1f);
    rc(ADDR_FLAGS, 32'h92);
    bus(1'b1, ADDR_WSEL, 32'h2);
    rc(ADDR_WDATA, 32'h40);
    bus(1'b1, ADDR_WSEL, 32'h5);
    rc(ADDR_WDATA, 32'hf0);
    bus(1'b1, ADDR_WSEL, 32'h4);
    rc(ADDR_WDATA, 32'hff);
    $display("flow test done");
    summarize();
  end
endmodule
`default_nettype wire
